// File: rtl/indwd_pkg.sv
package indwd_pkg;

    localparam int unsigned        CNT_W     = 14;
    localparam logic [CNT_W-1:0]   CNT_TOP   = 14'h3fff;
    localparam int unsigned        KEY_W     = 8;
    localparam logic [KEY_W-1:0]   KEY_FIRST = 8'h00;
    localparam logic [KEY_W-1:0]   KEY_SECOND = 8'hff;

    typedef enum logic [1:0] {
        ACT_RESET = 2'b00,
        ACT_NMI   = 2'b01,
        ACT_IRQ   = 2'b10
    } indwd_action_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } indwd_state_e;

endpackage

// File: rtl/indwd_top.sv
// Operation
// (R1) A 14-bit counter steps down once per counting clock edge toward underflow.
// (R2) Software must refresh often enough that underflow never occurs in normal use.
// (R3) Underflow raises one selected action: system reset, NMI or interrupt.
// (R4) The counter runs on its own dedicated oscillator, not the system clock.
// (R5) Start mode: restart automatically, or wait until software refreshes. Manual mode never starts if WIN_TOP < CNT_TOP (idle refresh errors).
// (R6) Refresh is two keys in order; wrong key or time is an error.
module indwd_top #(
    parameter logic [indwd_pkg::CNT_W-1:0] WIN_TOP = indwd_pkg::CNT_TOP
) (
    input  wire logic                        clk_i,
    input  wire logic                        srst_i,
    input  wire logic                        auto_start_i,
    input  wire logic [1:0]                  action_sel_i,
    input  wire logic                        refresh_wr_i,
    input  wire logic [indwd_pkg::KEY_W-1:0] refresh_data_i,
    output logic      [indwd_pkg::CNT_W-1:0] count_o,
    output logic                             counting_o,
    output logic                             reset_req_o,
    output logic                             nmi_o,
    output logic                             irq_o,
    output logic                             refresh_err_o
);

    indwd_pkg::indwd_state_e   state;
    indwd_pkg::indwd_state_e   next_state;
    logic [indwd_pkg::CNT_W-1:0] count;
    logic [indwd_pkg::CNT_W-1:0] next_count;
    logic                        seq_half;
    logic                        next_seq_half;
    logic                        next_reset_req;
    logic                        next_nmi;
    logic                        next_irq;
    logic                        next_refresh_err;
    logic                        underflow;
    logic                        key_err;
    logic                        key_ok;
    logic                        fire;
    logic                        next_counting;

    always_comb begin
        next_state       = state;
        next_count       = count;
        next_seq_half    = seq_half;
        key_err          = 1'b0;
        key_ok           = 1'b0;
        // A write outside the window is an error rather than ignored.
        // (R6) refresh key check
        if (refresh_wr_i) begin
            if (count > WIN_TOP) begin
                key_err = 1'b1;
            end else if (refresh_data_i == indwd_pkg::KEY_FIRST && !seq_half) begin
                next_seq_half = 1'b1;
            end else if (refresh_data_i == indwd_pkg::KEY_SECOND && seq_half) begin
                key_ok = 1'b1;
            end else begin
                key_err = 1'b1;
            end
        end
        // Underflow wins over a valid refresh landing on the same edge.
        underflow = (state == indwd_pkg::ST_RUN) && (count == '0);
        fire      = underflow || key_err;
        // (R3) action selection
        next_reset_req   = fire && (action_sel_i == indwd_pkg::ACT_RESET);
        next_nmi         = fire && (action_sel_i == indwd_pkg::ACT_NMI);
        next_irq         = fire && (action_sel_i != indwd_pkg::ACT_RESET)
                                && (action_sel_i != indwd_pkg::ACT_NMI);
        next_refresh_err = key_err;
        if (fire) begin
            next_count    = indwd_pkg::CNT_TOP;
            next_seq_half = 1'b0;
            next_state    = indwd_pkg::ST_IDLE;
        end else if (key_ok) begin
            next_count    = indwd_pkg::CNT_TOP;
            next_seq_half = 1'b0;
            next_state    = indwd_pkg::ST_RUN;
        end else begin
            case (state)
                indwd_pkg::ST_IDLE: begin
                    // (R5) automatic start
                    if (auto_start_i) begin
                        next_state = indwd_pkg::ST_RUN;
                    end
                end
                indwd_pkg::ST_RUN: begin
                    // (R1) count down
                    next_count = count - {{(indwd_pkg::CNT_W-1){1'b0}}, 1'b1};
                end
                default: begin
                    next_state = indwd_pkg::ST_IDLE;
                end
            endcase
        end
        next_counting    = (next_state == indwd_pkg::ST_RUN);
    end

    // (R4) dedicated counting clock
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state         <= indwd_pkg::ST_IDLE;
            count         <= indwd_pkg::CNT_TOP;
            seq_half      <= 1'b0;
            reset_req_o   <= 1'b0;
            nmi_o         <= 1'b0;
            irq_o         <= 1'b0;
            refresh_err_o <= 1'b0;
            count_o       <= indwd_pkg::CNT_TOP;
            counting_o    <= 1'b0;
        end else begin
            state         <= next_state;
            count         <= next_count;
            seq_half      <= next_seq_half;
            reset_req_o   <= next_reset_req;
            nmi_o         <= next_nmi;
            irq_o         <= next_irq;
            refresh_err_o <= next_refresh_err;
            count_o       <= next_count;
            counting_o    <= next_counting;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    count_steps_down_a: assert property ( // (R1)
        (state == indwd_pkg::ST_RUN && count != '0 && !refresh_wr_i)
        |=> count == $past(count) - 14'h0001 && count_o == count)
        else $error("Counter did not step down by one.");

    underflow_reset_a: assert property ( // (R3)
        (state == indwd_pkg::ST_RUN && count == '0 && !refresh_wr_i
         && action_sel_i == indwd_pkg::ACT_RESET)
        |=> reset_req_o && !nmi_o && !irq_o ##1 !reset_req_o)
        else $error("Underflow did not give a one-cycle reset request.");

    single_action_a: assert property ( // (R3)
        $onehot0({reset_req_o, nmi_o, irq_o}))
        else $error("More than one action raised at once.");

    manual_waits_a: assert property ( // (R5)
        (state == indwd_pkg::ST_IDLE && !auto_start_i && !refresh_wr_i)
        |=> !counting_o && count_o == indwd_pkg::CNT_TOP)
        else $error("Counter started without refresh in manual mode.");

    auto_starts_a: assert property ( // (R5)
        (state == indwd_pkg::ST_IDLE && auto_start_i && !refresh_wr_i)
        |=> counting_o ##1 count_o == 14'h3ffe)
        else $error("Automatic start did not begin counting.");

    refresh_reload_a: assert property ( // (R6)
        (refresh_wr_i && refresh_data_i == indwd_pkg::KEY_SECOND && seq_half
         && count <= WIN_TOP && !underflow)
        |=> count_o == indwd_pkg::CNT_TOP && counting_o && !refresh_err_o)
        else $error("Valid refresh did not reload the counter.");

    bad_key_error_a: assert property ( // (R6)
        (refresh_wr_i && refresh_data_i != indwd_pkg::KEY_FIRST
         && refresh_data_i != indwd_pkg::KEY_SECOND)
        |=> refresh_err_o && !counting_o)
        else $error("Wrong refresh key not reported as error.");

    underflow_action_a: assert property ( // (R3)
        (state == indwd_pkg::ST_RUN && count == '0 && !refresh_wr_i)
        |=> (reset_req_o || nmi_o || irq_o) && !counting_o
            && count_o == indwd_pkg::CNT_TOP)
        else $error("Underflow did not stop and reload the counter.");

    action_cause_a: assert property ( // (R3)
        (reset_req_o || nmi_o || irq_o)
        |-> $past(fire))
        else $error("Action raised without underflow or refresh error.");

    err_has_action_a: assert property ( // (R6)
        refresh_err_o
        |-> (reset_req_o || nmi_o || irq_o))
        else $error("Refresh error raised no action.");

    err_needs_write_a: assert property ( // (R6)
        refresh_err_o
        |-> $past(refresh_wr_i))
        else $error("Refresh error without a refresh write.");

    first_key_arm_a: assert property ( // (R6)
        (refresh_wr_i && refresh_data_i == indwd_pkg::KEY_FIRST && !seq_half
         && count <= WIN_TOP && !underflow)
        |=> seq_half && !refresh_err_o)
        else $error("First refresh key did not arm the sequence.");

    window_error_a: assert property ( // (R6)
        (refresh_wr_i && count > WIN_TOP)
        |=> refresh_err_o && !counting_o)
        else $error("Refresh outside the window not reported as error.");

    half_clears_a: assert property ( // (R6)
        fire
        |=> !seq_half)
        else $error("Refresh sequence not cleared after an action.");

    idle_full_a: assert property ( // (R5)
        (state == indwd_pkg::ST_IDLE)
        |-> count == indwd_pkg::CNT_TOP && !counting_o)
        else $error("Stopped counter does not hold its full value.");

    second_first_a: assert property ( // (R6)
        (refresh_wr_i && refresh_data_i == indwd_pkg::KEY_SECOND && !seq_half)
        |=> refresh_err_o)
        else $error("Second key without first key not reported as error.");

    double_first_a: assert property ( // (R6)
        (refresh_wr_i && refresh_data_i == indwd_pkg::KEY_FIRST && seq_half)
        |=> refresh_err_o)
        else $error("Repeated first key not reported as error.");

    underflow_cover: cover property (
        state == indwd_pkg::ST_RUN && count == '0 ##1 (reset_req_o || nmi_o || irq_o));
    refresh_cover: cover property (
        refresh_wr_i && refresh_data_i == indwd_pkg::KEY_FIRST
        ##1 refresh_wr_i && refresh_data_i == indwd_pkg::KEY_SECOND);
    error_cover: cover property (refresh_err_o && nmi_o);
    restart_cover: cover property (reset_req_o ##1 counting_o);
    window_cover: cover property (refresh_wr_i && count > WIN_TOP);

endmodule

// File: verification/independent_watchdog_timer_test.sv
module independent_watchdog_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i          = 1'b0;
    logic        srst_i         = 1'b1;
    logic        auto_start_i   = 1'b1;
    logic [1:0]  action_sel_i   = 2'h0;
    logic        refresh_wr_i   = 1'b0;
    logic [7:0]  refresh_data_i = 8'h00;
    logic [13:0] count_o;
    logic        counting_o, reset_req_o, nmi_o, irq_o, refresh_err_o;
    logic        win_err;
    int          fails = 0;
    int          total_checks = 0;
    int          n;
    always #50 clk_i = ~clk_i;
    indwd_top dut (.clk_i(clk_i), .srst_i(srst_i), .auto_start_i(auto_start_i),
        .action_sel_i(action_sel_i), .refresh_wr_i(refresh_wr_i),
        .refresh_data_i(refresh_data_i), .count_o(count_o), .counting_o(counting_o),
        .reset_req_o(reset_req_o), .nmi_o(nmi_o), .irq_o(irq_o),
        .refresh_err_o(refresh_err_o));
    indwd_top #(.WIN_TOP(14'h3ff0)) win (.clk_i(clk_i), .srst_i(srst_i),
        .auto_start_i(auto_start_i), .action_sel_i(action_sel_i),
        .refresh_wr_i(refresh_wr_i), .refresh_data_i(refresh_data_i), .count_o(),
        .counting_o(), .reset_req_o(), .nmi_o(), .irq_o(), .refresh_err_o(win_err));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic act(input logic [1:0] sel, input logic on);
        check({reset_req_o, nmi_o, irq_o}, !on ? 3'h0 : sel == 2'h0 ? 3'h4 :
            sel == 2'h1 ? 3'h2 : 3'h1, "action");
    endtask
    task automatic keys(input logic [7:0] a, input logic [7:0] b, input logic two);
        refresh_wr_i = 1'b1;
        refresh_data_i = a;
        step(1);
        refresh_data_i = b;
        if (two) step(1);
        refresh_wr_i = 1'b0;
    endtask
    task automatic do_reset(input logic auto);
        srst_i = 1'b1;
        auto_start_i = auto;
        step(6);
        check(count_o, 14'h3fff, "reset count");
        check(counting_o, 1'b0, "reset run");
        srst_i = 1'b0;
    endtask
    task automatic t_auto;
        do_reset(1'b1);
        n = 0;
        while (reset_req_o !== 1'b1 && n < 20000) begin
            step(1);
            n++;
            if (n == 2) check(count_o, 14'h3ffe, "decrement");
        end
        check(n, int'(indwd_pkg::CNT_TOP) + 2, "underflow cycle");
        act(2'h0, 1'b1);
        check(count_o, indwd_pkg::CNT_TOP, "underflow reload");
        check(counting_o, 1'b0, "stop");
        step(1);
        act(2'h0, 1'b0);
        check(counting_o, 1'b1, "auto restart");
    endtask
    task automatic t_manual;
        do_reset(1'b0);
        action_sel_i = 2'h1;
        step(3);
        check(counting_o, 1'b0, "manual wait");
        keys(8'h00, 8'hff, 1'b1);
        check(counting_o, 1'b1, "refresh start");
        check(refresh_err_o, 1'b0, "good refresh");
        check(win_err, 1'b1, "refresh outside window");
        step(5);
        check(count_o, 14'h3ffa, "count down");
        keys(8'h00, 8'hff, 1'b1);
        check(count_o, 14'h3fff, "reload");
        act(2'h1, 1'b0);
    endtask
    task automatic t_errors;
        logic [7:0] bad [3] = '{8'hff, 8'h5a, 8'h81};
        for (int i = 0; i < 4; i++) begin
            action_sel_i = i[1:0];
            step(1);
            if (i == 3) keys(8'h00, 8'h00, 1'b1);
            else keys(bad[i], 8'h00, 1'b0);
            check(refresh_err_o, 1'b1, "error");
            act(i[1:0], 1'b1);
            check(count_o, 14'h3fff, "error count");
            step(1);
            check(refresh_err_o, 1'b0, "error end");
            check(counting_o, 1'b0, "stopped");
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(30000 * 100);
        fails++;
        print_verdict();
    end
    initial begin
        t_auto();
        t_manual();
        t_errors();
        print_verdict();
    end
endmodule
